//--- adc_diag_defines.svh
// Offsets, field positions, reset values and codes of the register slice.
// Notes on behaviour
// - Group A selector is bits 2:0: 000 off, 011 pos, 100 neg, 101 zero.
// - Group B check selector is bits 6:4 with the same encoding as group A.
// - Mode A channels get the group A voltage, mode B channels group B.
// - The selector register resets to 0x00, so no voltage is applied.
// - Delay bits 3:2 pick none, channels 0 to 3, 4 to 7, or all channels.
// - The modulator delay register resets to 0x02.
// - Chop bits 3:2 hold group A, bits 1:0 group B, resetting to 0x0A.
// - Chop code 01 divides the modulator clock by 8, code 10 by 32.
// - A test voltage reaches a channel only when its receive bit is one.
`ifndef ADC_DIAG_DEFINES_SVH
`define ADC_DIAG_DEFINES_SVH
`define OFS_RECEIVE 8'h56
`define OFS_DIAG_SEL 8'h57
`define OFS_MOD_DELAY 8'h58
`define OFS_CHOP 8'h59
`define RST_DIAG_SEL 8'h00
`define RST_MOD_DELAY 8'h02
`define RST_CHOP 8'h0a
`define RST_RECEIVE 8'h00
`define GRP_A_LSB 0
`define GRP_B_LSB 4
`define DELAY_LSB 2
`define CHOP_A_LSB 2
`define CHOP_B_LSB 0
`define CODE_POS 3'h3
`define CODE_NEG 3'h4
`define CODE_ZERO 3'h5
`define CHOP_DIV8 2'h1
`define CHOP_DIV32 2'h2
`define NUM_CH 8
`endif

//--- adc_diag_pkg.sv
// Types shared by the diagnostic register slice.
package adc_diag_pkg;
  typedef enum logic [1:0] {
    TEST_OFF = 2'h0,
    TEST_POS = 2'h1,
    TEST_NEG = 2'h2,
    TEST_ZERO = 2'h3
  } test_volt_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef struct packed {
    logic [1:0] div8;
    logic [1:0] div32;
  } chop_rate_s;
endpackage

//--- adc_diag_decode.sv
// Decoder from a three-bit check selector code to a test voltage.
`include "adc_diag_defines.svh"
module adc_diag_decode
  import adc_diag_pkg::*;
(
  input wire logic [2:0] code,
  output adc_diag_pkg::test_volt_e volt
);
  import adc_diag_pkg::*;

  // Anything other than the three defined codes is treated as off.
  assign volt = (code == `CODE_POS) ? TEST_POS :
                (code == `CODE_NEG) ? TEST_NEG :
                (code == `CODE_ZERO) ? TEST_ZERO :
                TEST_OFF;
endmodule

//--- adc_diag_chop_delay_regs.sv
// Diagnostic selector, modulator delay and chop control register slice.
`include "adc_diag_defines.svh"
module adc_diag_chop_delay_regs
  import adc_diag_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input adc_diag_pkg::reg_req_s req,
  input wire logic [7:0] channel_mode_b,
  output logic [7:0] rdata,
  output logic [7:0] channel_zero_receive,
  output adc_diag_pkg::test_volt_e [7:0] channel_test_volt,
  output logic [7:0] delayed_mod_clock_en,
  output adc_diag_pkg::chop_rate_s group_a_chop_rate,
  output adc_diag_pkg::chop_rate_s group_b_chop_rate
);
  import adc_diag_pkg::*;

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] recv_q;
  logic [7:0] diag_q;
  logic [7:0] delay_q;
  logic [7:0] chop_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  wire hit_recv = req.addr == `OFS_RECEIVE;
  wire hit_diag = req.addr == `OFS_DIAG_SEL;
  wire hit_delay = req.addr == `OFS_MOD_DELAY;
  wire hit_chop = req.addr == `OFS_CHOP;

  // Reserved bits of the delay register are stored as written; software
  // must keep them at 0x2 because the core is not told what other values do.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      recv_q <= `RST_RECEIVE;
      diag_q <= `RST_DIAG_SEL;
      delay_q <= `RST_MOD_DELAY;
      chop_q <= `RST_CHOP;
    end
    else if (req.wr)
    begin
      if (hit_recv)
        recv_q <= req.wdata;
      if (hit_diag)
        diag_q <= req.wdata & 8'h77;
      if (hit_delay)
        delay_q <= req.wdata & 8'h0f;
      if (hit_chop)
        chop_q <= req.wdata & 8'h0f;
    end
  end

  // Unmapped addresses read as zero.
  assign rdata_d = hit_recv ? recv_q :
                   hit_diag ? diag_q :
                   hit_delay ? delay_q :
                   hit_chop ? chop_q : 8'h00;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (req.rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= 8'h00;
  end
  assign rdata = rdata_q;

  // ------------------------------------------------------------
  // Per-channel routing
  // ------------------------------------------------------------
  test_volt_e volt_a;
  test_volt_e volt_b;
  adc_diag_decode u_dec_a (
    .code(diag_q[`GRP_A_LSB +: 3]),
    .volt(volt_a)
  );
  adc_diag_decode u_dec_b (
    .code(diag_q[`GRP_B_LSB +: 3]),
    .volt(volt_b)
  );

  wire [1:0] delay_sel = delay_q[`DELAY_LSB +: 2];
  wire [1:0] chop_a = chop_q[`CHOP_A_LSB +: 2];
  wire [1:0] chop_b = chop_q[`CHOP_B_LSB +: 2];
  test_volt_e [7:0] volt_q;
  logic [7:0] dly_q;
  chop_rate_s chop_a_q;
  chop_rate_s chop_b_q;

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CH; ch++)
    begin : g_ch
      // The mode input is assumed steady; it is not resynchronised.
      wire test_volt_e pick = channel_mode_b[ch] ? volt_b : volt_a;
      wire test_volt_e gated = recv_q[ch] ? pick : TEST_OFF;
      wire dly = (ch < 4) ? delay_sel[0] : delay_sel[1];
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          volt_q[ch] <= TEST_OFF;
          dly_q[ch] <= 1'b0;
        end
        else
        begin
          volt_q[ch] <= gated;
          dly_q[ch] <= dly;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chop_a_q <= '{div8: 2'h0, div32: 2'h0};
      chop_b_q <= '{div8: 2'h0, div32: 2'h0};
    end
    else
    begin
      chop_a_q <= '{div8: {1'b0, chop_a == `CHOP_DIV8},
                    div32: {1'b0, chop_a == `CHOP_DIV32}};
      chop_b_q <= '{div8: {1'b0, chop_b == `CHOP_DIV8},
                    div32: {1'b0, chop_b == `CHOP_DIV32}};
    end
  end

  assign channel_zero_receive = recv_q;
  assign channel_test_volt = volt_q;
  assign delayed_mod_clock_en = dly_q;
  assign group_a_chop_rate = chop_a_q;
  assign group_b_chop_rate = chop_b_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  gate_recv_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !recv_q[0] |=> channel_test_volt[0] == TEST_OFF)
    else $error("Voltage on channel without receive.");
  mode_a_route_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    recv_q[1] && !channel_mode_b[1]
      |=> channel_test_volt[1] == $past(volt_a))
    else $error("Mode A channel did not follow group A.");
  mode_b_route_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    recv_q[2] && channel_mode_b[2]
      |=> channel_test_volt[2] == $past(volt_b))
    else $error("Mode B channel did not follow group B.");
  undef_off_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !(diag_q[2:0] inside {3'h0, `CODE_POS, `CODE_NEG, `CODE_ZERO})
      |-> volt_a == TEST_OFF)
    else $error("Undefined group A code gave a voltage.");
  undef_b_off_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !(diag_q[6:4] inside {3'h0, `CODE_POS, `CODE_NEG, `CODE_ZERO})
      |-> volt_b == TEST_OFF)
    else $error("Undefined group B code gave a voltage.");
  neg_code_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    diag_q[2:0] == 3'h4 |-> volt_a == TEST_NEG)
    else $error("Group A negative code misdecoded.");
  pos_code_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    diag_q[6:4] == 3'h3 |-> volt_b == TEST_POS)
    else $error("Group B positive code misdecoded.");
  zero_code_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    diag_q[2:0] == 3'h5 |-> volt_a == TEST_ZERO)
    else $error("Group A zero code misdecoded.");
  delay_half_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    delay_q[3:2] == 2'h1 ##1 delay_q[3:2] == 2'h1
      |-> delayed_mod_clock_en == 8'h0f)
    else $error("Delay half mismatch.");
  delay_high_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    delay_q[3:2] == 2'h2 |=> delayed_mod_clock_en == 8'hf0)
    else $error("Upper delay half mismatch.");
  delay_all_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    delay_q[3:2] == 2'h3 |=> delayed_mod_clock_en == 8'hff)
    else $error("Full delay mismatch.");
  chop_rate_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    chop_q[3:2] == 2'h2 |=> group_a_chop_rate.div32[0])
    else $error("Group A chop rate wrong.");
  chop_div8_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    chop_q[3:2] == 2'h1 |=> group_a_chop_rate.div8 == 2'h1)
    else $error("Group A fast chop rate wrong.");
  chop_b_rate_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    chop_q[1:0] == 2'h2 |=> group_b_chop_rate.div32 == 2'h1
      && group_b_chop_rate.div8 == 2'h0)
    else $error("Group B chop rate wrong.");
  diag_write_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    req.wr && hit_diag |=> diag_q == ($past(req.wdata) & 8'h77))
    else $error("Selector write not stored.");
  delay_write_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    req.wr && hit_delay |=> delay_q == ($past(req.wdata) & 8'h0f))
    else $error("Delay write not stored.");
  chop_write_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    req.wr && hit_chop |=> chop_q == ($past(req.wdata) & 8'h0f))
    else $error("Chop write not stored.");
  chop_read_a: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    req.rd && hit_chop |=> rdata == $past(chop_q))
    else $error("Chop read returned wrong data.");
  reset_vals_a: assert property (@(posedge core_clk)
    $rose(rst_n) |-> diag_q == 8'h00 && delay_q == 8'h02
      && chop_q == 8'h0a)
    else $error("Reset values wrong.");
endmodule

//--- adc_diag_chop_delay_regs_tb_top.sv
// Self-checking bench for the diagnostic, delay and chop register slice.
module adc_diag_chop_delay_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_diag_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
  logic core_clk, rst_n;
  reg_req_s req;
  logic [7:0] channel_mode_b, rdata;
  logic [7:0] channel_zero_receive, delayed_mod_clock_en;
  test_volt_e [7:0] channel_test_volt;
  chop_rate_s group_a_chop_rate, group_b_chop_rate;
  int n_mismatch, check_count, cycles;
  // Delay register writes always carry 0x2 in the reserved low bits.
  row_s rows[6] = '{'{8'h57, 8'hff, 8'h77}, '{8'h58, 8'hfe, 8'h0e},
    '{8'h59, 8'h05, 8'h05}, '{8'h56, 8'ha5, 8'ha5},
    '{8'h60, 8'h12, 8'h00}, '{8'h58, 8'h02, 8'h02}};
  logic [7:0] dexp[4] = '{8'h00, 8'h0f, 8'hf0, 8'hff};
  adc_diag_chop_delay_regs uut (.core_clk(core_clk), .rst_n(rst_n),
    .req(req), .channel_mode_b(channel_mode_b), .rdata(rdata),
    .channel_zero_receive(channel_zero_receive),
    .channel_test_volt(channel_test_volt),
    .delayed_mod_clock_en(delayed_mod_clock_en),
    .group_a_chop_rate(group_a_chop_rate),
    .group_b_chop_rate(group_b_chop_rate));
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    req <= '{a, d, 1'b0, 1'b0};
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    req <= '{a, 8'h00, 1'b0, 1'b0};
    #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  // Derived outputs trail the register by one edge, so wait one more.
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk_volt(input logic [1:0] va, input logic [1:0] vb,
    input logic [7:0] rx, input logic [7:0] mb);
    chk("volt", vexp(va, vb, rx, mb), channel_test_volt);
  endtask
  task automatic chk_chop(input logic [7:0] e);
    chk("chop", {8'h00, e}, {8'h00, group_a_chop_rate, group_b_chop_rate});
  endtask
  function automatic logic [15:0] vexp(input logic [1:0] va,
    input logic [1:0] vb, input logic [7:0] rx, input logic [7:0] mb);
    logic [15:0] r;
    for (int i = 0; i < 8; i++)
      r[2*i+:2] = rx[i] ? (mb[i] ? vb : va) : 2'b00;
    return r;
  endfunction
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    req = '0;
    channel_mode_b = 8'h3c;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk(8'h57, 8'h00);
    rd_chk(8'h58, 8'h02);
    rd_chk(8'h59, 8'h0a);
    chk_chop(8'h11);
    chk("volt", 16'h0000, channel_test_volt);
    chk("delay", 16'h0000, {8'h00, delayed_mod_clock_en});
    chk("receive", 16'h0000, {8'h00, channel_zero_receive});
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    wr(8'h56, 8'hff);
    settle();
    chk("receive", 16'h00ff, {8'h00, channel_zero_receive});
    wr(8'h57, 8'h53);
    settle();
    chk_volt(TEST_POS, TEST_ZERO, 8'hff, 8'h3c);
    wr(8'h57, 8'h44);
    settle();
    chk_volt(TEST_NEG, TEST_NEG, 8'hff, 8'h3c);
    wr(8'h56, 8'h0f);
    settle();
    chk_volt(TEST_NEG, TEST_NEG, 8'h0f, 8'h3c);
    wr(8'h56, 8'hff);
    @(posedge core_clk);
    channel_mode_b <= 8'hc3;
    wr(8'h57, 8'h35);
    settle();
    chk_volt(TEST_ZERO, TEST_POS, 8'hff, 8'hc3);
    wr(8'h57, 8'h17);
    settle();
    chk_volt(TEST_OFF, TEST_OFF, 8'hff, 8'hc3);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h58, {4'h0, c[1:0], 2'b10});
      settle();
      chk("delay", {8'h00, dexp[c]}, {8'h00, delayed_mod_clock_en});
    end
    wr(8'h59, 8'h06);
    settle();
    chk_chop(8'h41);
    wr(8'h59, 8'h0f);
    settle();
    chk_chop(8'h00);
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    rst_n <= 1'b1;
    chk_chop(8'h00);
    chk("volt", 16'h0000, channel_test_volt);
    chk("delay", 16'h0000, {8'h00, delayed_mod_clock_en});
    rd_chk(8'h57, 8'h00);
    rd_chk(8'h58, 8'h02);
    rd_chk(8'h59, 8'h0a);
    chk_chop(8'h11);
    chk("receive", 16'h0000, {8'h00, channel_zero_receive});
    end_sim();
  end
endmodule
